// >>> logic/panel_regs.svh
// Constants of the keypad and panel controller: bus offsets, fields,
// reset values, key positions and timing counts.
// Assumes a 10 MHz system clock and 32-bit APB data.
`ifndef PANEL_REGS_SVH
`define PANEL_REGS_SVH

// Register byte offsets
`define CFG_OFFSET        12'h000
`define STATUS_OFFSET     12'h004
`define EDIT_OFFSET       12'h008

// Configuration fields
`define CFG_MULTI_LSB     0
`define CFG_MULTI_MSB     2
`define CFG_SCOPE_BIT     3
`define CFG_QV_LSB        4
`define CFG_QV_MSB        5
`define MULTI_RESET       3'h0
`define SCOPE_RESET       1'h1
`define QV_RESET          2'h0

// Key positions in the key vector
`define KEY_PROG          0
`define KEY_ENTER         1
`define KEY_UP            2
`define KEY_DOWN          3
`define KEY_SHIFT         4
`define KEY_RUN           5
`define KEY_STOP          6
`define KEY_MULTI         7
`define KEY_QUICK         8
`define NUM_KEYS          9

// Timing
`define CLK_HZ            10000000
`define DEBOUNCE_MS       10
`define SLOW_BLINK_HZ     1
`define FAST_BLINK_HZ     4
`define DEBOUNCE_CYCLES   (`CLK_HZ / 1000 * `DEBOUNCE_MS)
`define SLOW_HALF_CYCLES  (`CLK_HZ / (2 * `SLOW_BLINK_HZ))
`define FAST_HALF_CYCLES  (`CLK_HZ / (2 * `FAST_BLINK_HZ))

// Monitor quantities and menu sizes
`define NUM_MONITOR       6
`define NUM_GROUPS        16
`define NUM_PARAMS        100
`define NUM_DIGITS        4

`endif

// >>> logic/panel_pkg.sv
// Types of the keypad and panel controller.
// Assumes panel_regs.svh for all numeric constants.
package panel_pkg;

  typedef enum logic [3:0] {
    ST_MONITOR = 4'h1,
    ST_GROUP   = 4'h2,
    ST_PARAM   = 4'h4,
    ST_VALUE   = 4'h8
  } menu_state_t;

  typedef enum logic [1:0] {
    SRC_KEYPAD   = 2'h0,
    SRC_TERMINAL = 2'h1,
    SRC_COMM     = 2'h2
  } cmd_source_t;

  typedef enum logic [1:0] {
    MODE_BASE     = 2'h0,
    MODE_USER_DEF = 2'h1,
    MODE_USER_MOD = 2'h2
  } menu_mode_t;

  typedef enum logic [4:0] {
    GL_HEX0 = 5'h00, GL_L = 5'h10, GL_N = 5'h11, GL_P = 5'h12,
    GL_R    = 5'h13, GL_T = 5'h14, GL_U = 5'h15, GL_U_SMALL = 5'h16,
    GL_BLANK = 5'h17, GL_S = 5'h18
  } glyph_t;

endpackage : panel_pkg

// >>> logic/key_debounce.sv
// One key input: two-stage synchroniser, debounce counter, press pulse.
// Assumes an active-high raw key from a pin, asynchronous to ref_clk.
`timescale 1ns/1ps
module key_debounce #(
  parameter int STABLE_CYCLES = 100000
) (
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic key_raw,
  output logic      press_evt
);
  logic        sync1_reg;
  logic        sync2_reg;
  logic        stable_reg;
  logic [31:0] cnt_reg;

  // Synchroniser
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= key_raw;
      sync2_reg <= sync1_reg;
    end
  end

  // Level must hold for the full window before it is accepted
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      cnt_reg    <= 32'h0;
      stable_reg <= 1'b0;
      press_evt  <= 1'b0;
    end
    else
    begin
      press_evt <= 1'b0;
      if (sync2_reg == stable_reg)
        cnt_reg <= 32'h0;
      else if (cnt_reg >= 32'(STABLE_CYCLES - 1))
      begin
        cnt_reg    <= 32'h0;
        stable_reg <= sync2_reg;
        press_evt  <= sync2_reg; // R22
      end
      else
        cnt_reg <= cnt_reg + 32'h1;
    end
  end
endmodule : key_debounce

// >>> logic/glyph_encoder.sv
// Character generator: glyph code to seven segments, bit order gfedcba.
// Assumes active-high segments; purely combinational.
`timescale 1ns/1ps
module glyph_encoder (
  input  wire logic [4:0] glyph,
  output logic      [6:0] seg
);
  // Digits, A-F, then letters; 5 and S share one glyph
  always_comb
  begin
    unique case (glyph) // R16
      5'h00: seg = 7'h3F;
      5'h01: seg = 7'h06;
      5'h02: seg = 7'h5B;
      5'h03: seg = 7'h4F;
      5'h04: seg = 7'h66;
      5'h05: seg = 7'h6D;
      5'h06: seg = 7'h7D;
      5'h07: seg = 7'h07;
      5'h08: seg = 7'h7F;
      5'h09: seg = 7'h6F;
      5'h0A: seg = 7'h77;
      5'h0B: seg = 7'h7C;
      5'h0C: seg = 7'h39;
      5'h0D: seg = 7'h5E;
      5'h0E: seg = 7'h79;
      5'h0F: seg = 7'h71;
      5'h10: seg = 7'h38;
      5'h11: seg = 7'h37;
      5'h12: seg = 7'h73;
      5'h13: seg = 7'h31;
      5'h14: seg = 7'h78;
      5'h15: seg = 7'h3E;
      5'h16: seg = 7'h1C;
      5'h18: seg = 7'h6D;
      default: seg = 7'h00;
    endcase
  end
endmodule : glyph_encoder

// >>> logic/keypad_menu_panel_control.sv
// Keypad, menu, LED and display control of the drive operating panel.
// Assumes raw keys from pins, drive status from core logic on ref_clk,
// and an APB master for the configuration registers.
// Notes on behaviour
// R1: program key enters/leaves group level, steps back from deeper levels.
// R2: confirm key descends a level and accepts the shown setting.
// R3: increment moves up, raises edited value, raises speed when running.
// R4: decrement moves down, lowers edited value, lowers speed when running.
// R5: shift cycles monitored quantity, or moves the edited digit.
// R6: run key starts the drive only under keypad command source.
// R7: stop key stops or clears fault; scope 0 keypad only, 1 always.
// R8: multi key: off, to keypad, toggle direction, forward jog, reverse jog.
// R9: quick key cycles menu modes allowed by two-bit display select.
// R10: run LED dark when stopped, lit when running.
// R11: source LED dark keypad, steady terminal, blinking communication.
// R12: direction LED lit forward, dark reverse.
// R13: tune LED steady torque, 1 Hz blink tuning, 4 Hz blink fault.
// R14: three unit LEDs singly or paired show unit of shown quantity.
// R15: five digits show reference, output frequency, monitor or fault code.
// R16: glyphs cover 0-9 and A B C D E F L N P R T U u; 5 equals S.
// R17: menu has group, parameter and value levels.
// R18: confirm at value level stores, returns, selects next parameter.
// R19: program key at value level discards and keeps parameter.
// R20: read-only parameters show no blinking digit and refuse changes.
// R21: stop-only parameters refuse edits while running.
// R22: each key press is debounced into one single-cycle event.
`timescale 1ns/1ps
`include "panel_regs.svh"
module keypad_menu_panel_control #(
  parameter int DEBOUNCE_CYCLES  = `DEBOUNCE_CYCLES,
  parameter int SLOW_HALF_CYCLES = `SLOW_HALF_CYCLES,
  parameter int FAST_HALF_CYCLES = `FAST_HALF_CYCLES,
  parameter int NUM_GROUPS       = `NUM_GROUPS,
  parameter int NUM_PARAMS       = `NUM_PARAMS
) (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic [8:0]  key_raw,
  input  wire logic        drive_running,
  input  wire logic        drive_fault,
  input  wire logic        drive_forward,
  input  wire logic [1:0]  cmd_source,
  input  wire logic        torque_mode,
  input  wire logic        autotuning,
  input  wire logic        param_read_only,
  input  wire logic        param_stop_only,
  input  wire logic [15:0] param_value,
  input  wire logic [15:0] monitor_value,
  input  wire logic [7:0]  fault_code,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             start_req,
  output logic             stop_req,
  output logic             fault_clear_req,
  output logic             speed_up_req,
  output logic             speed_down_req,
  output logic             src_to_keypad_req,
  output logic             dir_toggle_req,
  output logic             jog_fwd_req,
  output logic             jog_rev_req,
  output logic             param_write_req,
  output logic      [15:0] param_wdata,
  output logic      [3:0]  param_group,
  output logic      [7:0]  param_index,
  output logic      [2:0]  monitor_sel,
  output logic      [1:0]  menu_mode,
  output logic             run_led,
  output logic             command_source_led,
  output logic             direction_led,
  output logic             tune_torque_led,
  output logic      [2:0]  unit_led,
  output logic      [34:0] seg_out
);
  logic [8:0]             key_evt;
  logic [2:0]             multi_action_select;
  logic                   stop_key_scope;
  logic [1:0]             quickview_display_select;
  panel_pkg::menu_state_t state_reg;
  logic [15:0]            edit_reg;
  logic [1:0]             digit_reg;
  logic [31:0]            slow_cnt_reg;
  logic [31:0]            fast_cnt_reg;
  logic                   slow_phase_reg;
  logic                   fast_phase_reg;
  logic                   editable;
  logic                   keypad_src;
  logic [4:0]             glyph [5];
  logic [6:0]             seg_next [5];
  // One debouncer per key
  for (genvar k = 0; k < `NUM_KEYS; k++)
  begin : g_key
    key_debounce #(.STABLE_CYCLES (DEBOUNCE_CYCLES)) u_deb (
      .ref_clk   (ref_clk),
      .nrst      (nrst),
      .key_raw   (key_raw[k]),
      .press_evt (key_evt[k])
    );
  end
  // Source decode; protected parameters cannot be changed
  assign keypad_src = (cmd_source == panel_pkg::SRC_KEYPAD);
  assign editable = !param_read_only && !(param_stop_only && drive_running); // R20 R21
  // APB slave, one wait state per access
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      {pready, pslverr, prdata} <= '0;
      {multi_action_select, stop_key_scope, quickview_display_select}
        <= {`MULTI_RESET, `SCOPE_RESET, `QV_RESET};
    end
    else
    begin
      pready  <= psel && penable && !pready;
      pslverr <= 1'b0;
      if (psel && penable && !pready)
      begin
        prdata <= 32'h0;
        unique case (paddr)
          `CFG_OFFSET:
            prdata <= {26'h0, quickview_display_select, stop_key_scope, multi_action_select};
          `STATUS_OFFSET:
            prdata <= {9'h0, monitor_sel, param_group, param_index, 2'h0, menu_mode, state_reg};
          `EDIT_OFFSET:
            prdata <= {14'h0, digit_reg, edit_reg};
          default: pslverr <= 1'b1;
        endcase
      end
      if (psel && penable && pready && pwrite && paddr == `CFG_OFFSET)
      begin
        multi_action_select      <= pwdata[`CFG_MULTI_MSB:`CFG_MULTI_LSB];
        stop_key_scope           <= pwdata[`CFG_SCOPE_BIT];
        quickview_display_select <= pwdata[`CFG_QV_MSB:`CFG_QV_LSB];
      end
    end
  end
  // Menu level state machine
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      state_reg <= panel_pkg::ST_MONITOR;
      {param_group, param_index, edit_reg, digit_reg, param_write_req, param_wdata} <= '0;
    end
    else
    begin
      param_write_req <= 1'b0;
      unique case (state_reg) // R17
        panel_pkg::ST_MONITOR:
          if (key_evt[`KEY_PROG])
            state_reg <= panel_pkg::ST_GROUP; // R1
        panel_pkg::ST_GROUP:
        begin
          if (key_evt[`KEY_PROG])
            state_reg <= panel_pkg::ST_MONITOR; // R1
          else if (key_evt[`KEY_ENTER])
          begin
            state_reg   <= panel_pkg::ST_PARAM; // R2
            param_index <= 8'h0;
          end
          else if (key_evt[`KEY_UP])
            param_group <= (param_group == 4'(NUM_GROUPS - 1)) ? 4'h0 : param_group + 4'h1; // R3
          else if (key_evt[`KEY_DOWN])
            param_group <= (param_group == 4'h0) ? 4'(NUM_GROUPS - 1) : param_group - 4'h1; // R4
        end
        panel_pkg::ST_PARAM:
        begin
          if (key_evt[`KEY_PROG])
            state_reg <= panel_pkg::ST_GROUP; // R1
          else if (key_evt[`KEY_ENTER])
          begin
            state_reg <= panel_pkg::ST_VALUE; // R2
            edit_reg  <= param_value;
            digit_reg <= 2'h0;
          end
          else if (key_evt[`KEY_UP])
            param_index <= (param_index == 8'(NUM_PARAMS - 1)) ? 8'h0 : param_index + 8'h1; // R3
          else if (key_evt[`KEY_DOWN])
            param_index <= (param_index == 8'h0) ? 8'(NUM_PARAMS - 1) : param_index - 8'h1; // R4
        end
        panel_pkg::ST_VALUE:
        begin
          if (key_evt[`KEY_PROG])
            state_reg <= panel_pkg::ST_PARAM; // R19
          else if (key_evt[`KEY_ENTER])
          begin
            state_reg       <= panel_pkg::ST_PARAM; // R18
            param_write_req <= editable; // R2 R20 R21
            param_wdata     <= edit_reg;
            param_index <= (param_index == 8'(NUM_PARAMS - 1)) ? 8'h0 : param_index + 8'h1; // R18
          end
          else if (key_evt[`KEY_UP] && editable)
            edit_reg <= edit_reg + (16'h1 << {digit_reg, 2'b00}); // R3
          else if (key_evt[`KEY_DOWN] && editable)
            edit_reg <= edit_reg - (16'h1 << {digit_reg, 2'b00}); // R4
          else if (key_evt[`KEY_SHIFT] && editable)
            digit_reg <= digit_reg + 2'h1; // R5
        end
        default: state_reg <= panel_pkg::ST_MONITOR;
      endcase
    end
  end
  // Monitor selection and quick-view menu mode
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      {monitor_sel, menu_mode} <= '0;
    else
    begin
      if (key_evt[`KEY_SHIFT] && state_reg == panel_pkg::ST_MONITOR)
        monitor_sel <= (monitor_sel == 3'(`NUM_MONITOR - 1)) ? 3'h0 : monitor_sel + 3'h1; // R5
      if (key_evt[`KEY_QUICK])
      begin
        unique case (menu_mode) // R9
          panel_pkg::MODE_BASE:
            menu_mode <= quickview_display_select[0] ? panel_pkg::MODE_USER_DEF
                       : quickview_display_select[1] ? panel_pkg::MODE_USER_MOD
                       : panel_pkg::MODE_BASE;
          panel_pkg::MODE_USER_DEF:
            menu_mode <= quickview_display_select[1] ? panel_pkg::MODE_USER_MOD
                       : panel_pkg::MODE_BASE;
          default: menu_mode <= panel_pkg::MODE_BASE;
        endcase
      end
    end
  end
  // Drive commands from the keys
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      {start_req, stop_req, fault_clear_req, speed_up_req, speed_down_req} <= '0;
      {src_to_keypad_req, dir_toggle_req, jog_fwd_req, jog_rev_req} <= '0;
    end
    else
    begin
      start_req <= key_evt[`KEY_RUN] && keypad_src; // R6
      stop_req <= key_evt[`KEY_STOP] && (stop_key_scope || keypad_src) && drive_running; // R7
      fault_clear_req <= key_evt[`KEY_STOP] && (stop_key_scope || keypad_src) && drive_fault; // R7
      speed_up_req    <= key_evt[`KEY_UP] && drive_running
                         && state_reg == panel_pkg::ST_MONITOR; // R3
      speed_down_req  <= key_evt[`KEY_DOWN] && drive_running
                         && state_reg == panel_pkg::ST_MONITOR; // R4
      src_to_keypad_req <= key_evt[`KEY_MULTI] && multi_action_select == 3'h1 && !keypad_src; // R8
      dir_toggle_req  <= key_evt[`KEY_MULTI] && multi_action_select == 3'h2; // R8
      jog_fwd_req     <= key_evt[`KEY_MULTI] && multi_action_select == 3'h3; // R8
      jog_rev_req     <= key_evt[`KEY_MULTI] && multi_action_select == 3'h4; // R8
    end
  end
  // Blink timebases; each phase flips as its counter wraps
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      {slow_cnt_reg, fast_cnt_reg, slow_phase_reg, fast_phase_reg} <= '0;
    else
    begin
      slow_cnt_reg <= (slow_cnt_reg >= 32'(SLOW_HALF_CYCLES - 1)) ? 32'h0 : slow_cnt_reg + 32'h1;
      fast_cnt_reg <= (fast_cnt_reg >= 32'(FAST_HALF_CYCLES - 1)) ? 32'h0 : fast_cnt_reg + 32'h1;
      slow_phase_reg <= slow_phase_reg ^ (slow_cnt_reg >= 32'(SLOW_HALF_CYCLES - 1));
      fast_phase_reg <= fast_phase_reg ^ (fast_cnt_reg >= 32'(FAST_HALF_CYCLES - 1));
    end
  end
  // Status and unit LEDs; unit order is Hz, A, V
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      {run_led, command_source_led, direction_led, tune_torque_led, unit_led} <= '0;
    else
    begin
      run_led            <= drive_running; // R10
      command_source_led <= (cmd_source == panel_pkg::SRC_TERMINAL)
                         || (cmd_source == panel_pkg::SRC_COMM && slow_phase_reg); // R11
      direction_led      <= drive_forward; // R12
      if (drive_fault)
        tune_torque_led <= fast_phase_reg; // R13
      else if (autotuning)
        tune_torque_led <= slow_phase_reg; // R13
      else
        tune_torque_led <= torque_mode; // R13
      if (state_reg != panel_pkg::ST_MONITOR || drive_fault)
        unit_led <= 3'h0;
      else
      begin
        unique case (monitor_sel) // R14
          3'h0, 3'h1: unit_led <= 3'h4;
          3'h2:       unit_led <= 3'h2;
          3'h3:       unit_led <= 3'h1;
          3'h4:       unit_led <= 3'h6;
          default:    unit_led <= 3'h3;
        endcase
      end
    end
  end
  // Glyph selection for the five digits, leftmost is index 4
  always_comb
  begin
    glyph = '{default: panel_pkg::GL_BLANK};
    if (drive_fault && state_reg == panel_pkg::ST_MONITOR)
    begin
      glyph[4] = 5'h0E; // R15
      glyph[1] = {1'b0, fault_code[7:4]};
      glyph[0] = {1'b0, fault_code[3:0]};
    end
    else
    begin
      unique case (state_reg)
        panel_pkg::ST_MONITOR:
          for (int i = 0; i < `NUM_DIGITS; i++)
            glyph[i] = {1'b0, monitor_value[4*i +: 4]}; // R15
        panel_pkg::ST_GROUP:
        begin
          glyph[4] = 5'h0F;
          glyph[3] = {1'b0, param_group};
        end
        panel_pkg::ST_PARAM:
        begin
          glyph[4] = 5'h0F;
          glyph[3] = {1'b0, param_group};
          glyph[1] = {1'b0, param_index[7:4]};
          glyph[0] = {1'b0, param_index[3:0]};
        end
        default:
        begin
          for (int i = 0; i < `NUM_DIGITS; i++)
            glyph[i] = {1'b0, edit_reg[4*i +: 4]};
          if (editable && slow_phase_reg)
            glyph[digit_reg] = panel_pkg::GL_BLANK; // R20
        end
      endcase
    end
  end
  // Segment encoders, one per digit
  for (genvar d = 0; d < 5; d++)
  begin : g_digit
    glyph_encoder u_enc (.glyph (glyph[d]), .seg (seg_next[d]));
  end
  // Registered segment outputs
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      seg_out <= 35'h0;
    else
      seg_out <= {seg_next[4], seg_next[3], seg_next[2], seg_next[1], seg_next[0]}; // R15
  end
endmodule : keypad_menu_panel_control

// >>> sim/panel_monitor.sv
// Checker on the panel controller ports.
// Assumes it is bound onto keypad_menu_panel_control.
`timescale 1ns/1ps
module panel_monitor (
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic       drive_running,
  input wire logic       drive_fault,
  input wire logic       drive_forward,
  input wire logic [1:0] cmd_source,
  input wire logic       torque_mode,
  input wire logic       autotuning,
  input wire logic       param_read_only,
  input wire logic       param_stop_only,
  input wire logic       start_req,
  input wire logic       fault_clear_req,
  input wire logic       speed_up_req,
  input wire logic       param_write_req,
  input wire logic       run_led,
  input wire logic       direction_led,
  input wire logic       command_source_led,
  input wire logic       tune_torque_led
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  // LED levels follow status one cycle later
  AST_RUN_LED: assert property ($past(nrst) |-> run_led == $past(drive_running))
    else $error("run led");
  AST_DIR_LED: assert property ($past(nrst) |-> direction_led == $past(drive_forward))
    else $error("dir led");
  AST_SRC_KEY: assert property ($past(nrst) && $past(cmd_source) == 2'h0
    |-> !command_source_led) else $error("src led keypad");
  AST_SRC_TERM: assert property ($past(nrst) && $past(cmd_source) == 2'h1
    |-> command_source_led) else $error("src led terminal");
  AST_TORQUE: assert property ($past(nrst) && $past(torque_mode) && !$past(autotuning)
    && !$past(drive_fault) |-> tune_torque_led) else $error("tune led");
  // Command pulses and their causes
  AST_START: assert property (start_req |-> $past(cmd_source) == 2'h0 ##1 !start_req)
    else $error("start pulse");
  AST_CLEAR: assert property (fault_clear_req |-> $past(drive_fault))
    else $error("clear without fault");
  AST_SPEED: assert property (speed_up_req |-> $past(drive_running))
    else $error("speed while stopped");
  AST_WRITE: assert property (param_write_req |-> !$past(param_read_only)
    && !($past(param_stop_only) && $past(drive_running))) else $error("protected write");
endmodule : panel_monitor

bind keypad_menu_panel_control panel_monitor panel_monitor_i (.ref_clk, .nrst,
  .drive_running, .drive_fault, .drive_forward, .cmd_source, .torque_mode, .autotuning,
  .param_read_only, .param_stop_only, .start_req, .fault_clear_req, .speed_up_req,
  .param_write_req, .run_led, .direction_led, .command_source_led, .tune_torque_led);

// >>> sim/panel_operator.sv
// Operator model: presses one key at a time with contact bounce.
// Assumes press() is called right after a rising clock edge.
`timescale 1ns/1ps
module panel_operator (
  input  wire logic       ref_clk,
  output logic      [8:0] key_raw
);
  initial key_raw = 9'h000;
  // Bounce on make and break, shorter than the debounce window
  task automatic press(input int k);
    key_raw[k] <= 1'b1;
    @(posedge ref_clk);
    key_raw[k] <= 1'b0;
    @(posedge ref_clk);
    key_raw[k] <= 1'b1;
    repeat (12) @(posedge ref_clk);
    key_raw[k] <= 1'b0;
    @(posedge ref_clk);
    key_raw[k] <= 1'b1;
    @(posedge ref_clk);
    key_raw[k] <= 1'b0;
    repeat (14) @(posedge ref_clk);
  endtask : press
endmodule : panel_operator

// >>> sim/tb_keypad_menu_panel_control.sv
// Bench for the panel controller: APB, keys, menu, LEDs, display.
// Assumes panel_operator for keys and panel_monitor bound in.
`timescale 1ns/1ps
module tb_keypad_menu_panel_control;
  logic        ref_clk, nrst, drive_running, drive_fault, drive_forward;
  logic        torque_mode, autotuning, param_read_only, param_stop_only;
  logic [1:0]  cmd_source, mode;
  logic [15:0] param_value, wdata;
  logic [11:0] paddr;
  logic        psel, penable, pwrite, pready, pslverr, er;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0]  key_raw;
  logic [9:0]  ev;
  logic [2:0]  msel, unit;
  logic        run_led, src_led, dir_led, tune_led;
  logic [34:0] seg;
  logic [2:0]  ut [6] = '{3'h4, 3'h4, 3'h2, 3'h1, 3'h6, 3'h3};
  int          cnt [10];
  int          n_fail, checks, q, m;

  panel_operator panel_operator_i (.ref_clk, .key_raw);
  keypad_menu_panel_control #(.DEBOUNCE_CYCLES(4), .SLOW_HALF_CYCLES(20),
    .FAST_HALF_CYCLES(5)) keypad_menu_panel_control_i (.ref_clk, .nrst, .key_raw,
    .drive_running, .drive_fault, .drive_forward, .cmd_source, .torque_mode, .autotuning,
    .param_read_only, .param_stop_only, .param_value, .monitor_value(16'h0000),
    .fault_code(8'h5A), .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .start_req(ev[0]), .stop_req(ev[1]), .fault_clear_req(ev[2]),
    .speed_up_req(ev[3]), .speed_down_req(ev[4]), .src_to_keypad_req(ev[5]),
    .dir_toggle_req(ev[6]), .jog_fwd_req(ev[7]), .jog_rev_req(ev[8]),
    .param_write_req(ev[9]), .param_wdata(wdata), .param_group(), .param_index(),
    .monitor_sel(msel), .menu_mode(mode), .run_led, .command_source_led(src_led),
    .direction_led(dir_led), .tune_torque_led(tune_led), .unit_led(unit), .seg_out(seg));

  // Clock, pulse counters, watchdog
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
    foreach (cnt[i]) cnt[i] += ev[i];
  initial
  begin
    #2000000;
    n_fail++;
    report_and_stop();
  end

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    repeat (20)
    begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cfg(input logic [2:0] ms, input logic s, input logic [1:0] qv);
    apb(1'b1, 12'h000, {26'h0, qv, s, ms});
  endtask : cfg

  task automatic stat(input logic [11:0] exp);
    apb(1'b0, 12'h004, 32'h0);
    chk({rd[15:8], rd[3:0]}, exp);
  endtask : stat

  task automatic edit(input logic [17:0] exp);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd[17:0], exp);
  endtask : edit

  task automatic key(input int k, input logic [9:0] exp);
    logic [9:0] got;
    int n;
    foreach (cnt[i]) cnt[i] = 0;
    panel_operator_i.press(k);
    n = 0;
    foreach (cnt[i])
    begin
      got[i] = cnt[i] != 0;
      n += cnt[i];
    end
    chk(got, exp);
    chk(n, $countones(exp));
  endtask : key

  task automatic blink(input logic w, input int lo, input int hi);
    int n;
    logic p;
    n = 0;
    repeat (3) @(posedge ref_clk);
    p = w ? tune_led : src_led;
    repeat (80)
    begin
      @(posedge ref_clk);
      if ((w ? tune_led : src_led) !== p) n++;
      p = w ? tune_led : src_led;
    end
    chk(n >= lo && n <= hi, 1'b1);
  endtask : blink

  // Menu walk with store and discard
  task automatic t_menu;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h8);
    apb(1'b0, 12'h00C, 32'h0);
    chk({er, rd}, {1'b1, 32'h0});
    stat(12'h001);
    key(0, 10'h0);
    stat(12'h002);
    key(1, 10'h0);
    stat(12'h004);
    key(1, 10'h0);
    edit(18'h01234);
    key(2, 10'h0);
    edit(18'h01235);
    key(4, 10'h0);
    edit(18'h11235);
    key(1, 10'h200);
    chk(wdata, 16'h1235);
    stat(12'h014);
    key(1, 10'h0);
    key(3, 10'h0);
    edit(18'h01233);
    key(0, 10'h0);
    stat(12'h014);
    key(0, 10'h0);
    stat(12'h012);
    key(0, 10'h0);
    stat(12'h011);
    $display("end t_menu");
  endtask : t_menu

  // Read-only and stop-only parameters
  task automatic t_protect;
    param_read_only <= 1'b1;
    key(0, 10'h0);
    key(1, 10'h0);
    key(1, 10'h0);
    key(2, 10'h0);
    edit(18'h01234);
    key(1, 10'h0);
    param_read_only <= 1'b0;
    param_stop_only <= 1'b1;
    drive_running <= 1'b1;
    key(1, 10'h0);
    key(3, 10'h0);
    edit(18'h01234);
    key(1, 10'h0);
    drive_running <= 1'b0;
    key(1, 10'h0);
    key(3, 10'h0);
    edit(18'h01233);
    param_stop_only <= 1'b0;
    key(0, 10'h0);
    key(0, 10'h0);
    key(0, 10'h0);
    $display("end t_protect");
  endtask : t_protect

  // Run, speed, stop scope, fault clear and display
  task automatic t_keys;
    cmd_source <= 2'h1;
    key(5, 10'h0);
    cmd_source <= 2'h0;
    key(5, 10'h001);
    drive_running <= 1'b1;
    key(2, 10'h008);
    key(3, 10'h010);
    cmd_source <= 2'h1;
    cfg(3'h0, 1'b0, 2'h0);
    key(6, 10'h0);
    cfg(3'h0, 1'b1, 2'h0);
    key(6, 10'h002);
    drive_running <= 1'b0;
    drive_fault <= 1'b1;
    key(6, 10'h004);
    chk(seg, {7'h79, 14'h0, 7'h6D, 7'h77});
    chk(unit, 3'h0);
    blink(1'b1, 15, 16);
    drive_fault <= 1'b0;
    for (m = 0; m < 5; m++)
    begin
      cfg(m[2:0], 1'b1, 2'h0);
      key(7, (m == 0) ? 10'h000 : 10'h010 << m);
    end
    $display("end t_keys");
  endtask : t_keys

  // Quick key modes, monitor units and LEDs
  task automatic t_leds;
    for (q = 3; q >= 0; q--)
    begin
      cfg(3'h0, 1'b1, q[1:0]);
      m = 0;
      repeat ((q == 3) ? 3 : 2)
      begin
        key(8, 10'h0);
        m = (m == 0 && q[0]) ? 1 : (m != 2 && q[1]) ? 2 : 0;
        chk(mode, m);
      end
    end
    for (m = 1; m <= 6; m++)
    begin
      key(4, 10'h0);
      chk({msel, unit}, {m[2:0] % 3'h6, ut[m % 6]});
    end
    cmd_source <= 2'h2;
    blink(1'b0, 3, 4);
    cmd_source <= 2'h0;
    autotuning <= 1'b1;
    blink(1'b1, 3, 4);
    autotuning <= 1'b0;
    torque_mode <= 1'b1;
    drive_running <= 1'b1;
    drive_forward <= 1'b1;
    blink(1'b1, 0, 0);
    chk({run_led, dir_led, tune_led}, 3'h7);
    $display("end t_leds");
  endtask : t_leds

  task automatic report_and_stop;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // Reset, then the scenarios in turn
  initial
  begin
    {nrst, drive_running, drive_fault, drive_forward, torque_mode} = '0;
    {autotuning, param_read_only, param_stop_only, psel, penable, pwrite} = '0;
    cmd_source = 2'h0;
    param_value = 16'h1234;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    t_menu();
    t_protect();
    t_keys();
    t_leds();
    report_and_stop();
  end
endmodule : tb_keypad_menu_panel_control
